// ### bench/dacdp_host.sv
// host model that drives the register strobe port
`timescale 1ns/1ps
module dacdp_host (
  input  wire logic       clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [4:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rd_data
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h1f;
    reg_wdata = 8'h00;
  end
  // one strobe per access, then a spare cycle
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
    @(posedge clk);
    #1;
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] v);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    reg_addr = ~a;
    v = reg_rd_data;
    @(posedge clk);
    #1;
  endtask : rd
endmodule : dacdp_host

// ### bench/tb_dacdp_cfg_regs.sv
// self-checking bench for the datapath configuration registers
`timescale 1ns/1ps
module tb_dacdp_cfg_regs;
  logic        clk, sys_rst, clk_en, reg_wr, reg_rd, pll_locked, dll_locked;
  logic        sync_pin_level, fifo_sync_disable, fifo_word_valid;
  logic        selftest_failed, fifo_overrun, core_selftest_on, tx_enable;
  logic        fifo_offset_load, serial_out_pin, serial_out_drive;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rd_data, d, c1, c2, c3;
  logic [12:0] chan_a_offset_value, chan_b_offset_value;
  logic [15:0] fifo_word, converter_chan_a, converter_chan_b;
  logic [2:0]  fifo_ptr_offset, ev, fx;
  logic [31:0] r, p, s;
  int          bad_count, comparisons, cycles, loads, seed, n, i, j;
  dacdp_pkg::dacdp_pair_t samp_in;
  dacdp_pkg::dacdp_mode_t mode;
  logic [7:0]  rst_val [6] = '{8'h14, 8'h10, 8'hc0, 8'h70, 8'h00, 8'h00};

  dacdp_cfg_regs i_dacdp_cfg_regs (.clk, .sys_rst, .clk_en, .reg_wr, .reg_rd,
    .reg_addr, .reg_wdata, .reg_rd_data, .pll_locked, .dll_locked,
    .sync_pin_level, .fifo_sync_disable, .chan_a_offset_value,
    .chan_b_offset_value, .samp_in, .fifo_word_valid, .fifo_word,
    .selftest_failed, .fifo_overrun, .mode, .core_selftest_on,
    .fifo_ptr_offset, .fifo_offset_load, .tx_enable, .serial_out_pin,
    .serial_out_drive, .converter_chan_a, .converter_chan_b);
  dacdp_host h (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rd_data);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // count load pulses away from the edge that launches them
  always @(negedge clk) begin
    if (fifo_offset_load === 1'b1)
      loads++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      complete_run();
    end
  end

  task automatic check(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : complete_run

  // format, offset, swap, then copy
  function automatic logic [31:0] dp(input logic [31:0] v);
    logic [15:0] a, b, t;
    a = v[31:16];
    b = v[15:0];
    if (!c2[7]) begin
      a[15] = ~a[15];
      b[15] = ~b[15];
    end
    if (c3[7]) begin
      a = a + {{3{chan_a_offset_value[12]}}, chan_a_offset_value};
      b = b + {{3{chan_b_offset_value[12]}}, chan_b_offset_value};
    end
    t = a;
    if (c3[3]) begin
      a = b;
      b = t;
    end
    if (c3[2])
      b = a;
    return {a, b};
  endfunction : dp

  initial begin
    seed = 77493;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {pll_locked, dll_locked, sync_pin_level, fifo_sync_disable} = 4'h0;
    {fifo_word_valid, selftest_failed, fifo_overrun} = 3'h0;
    chan_a_offset_value = 13'h0000;
    chan_b_offset_value = 13'h0000;
    samp_in = 32'h00000000;
    fifo_word = 16'h1234;
    repeat (12) @(posedge clk);
    #1 sys_rst = 1'b0;
    check("mode", mode, 8'he0);
    for (i = 0; i < 6; i++) begin
      h.rd(i[4:0], d);
      check("reset", d, rst_val[i]);
    end
    for (i = 0; i < 32; i++) begin
      r = $random(seed);
      c1 = {i[1:0], r[5:0]};
      c2 = {r[7:4], i[3:0]};
      c3 = r[15:8] & 8'hfc;
      h.wr(5'h01, c1);
      h.wr(5'h02, c2);
      h.wr(5'h03, c3);
      h.wr(5'h00, r[23:16]);
      h.rd(5'h01, d);
      check("cfg1", d, c1 & 8'hdf);
      h.rd(5'h02, d);
      check("cfg2", d, c2 & 8'hef);
      h.rd(5'h03, d);
      check("cfg3", d, c3);
      h.rd(5'h00, d);
      check("lock_and_identity_status", d, 8'h14);
      check("mode", mode, {c1[4], c2[7:5], c2[3:0]});
      check("test", {core_selftest_on, serial_out_drive}, {2{c1[3]}});
      check("offset", fifo_ptr_offset, c1[2:0]);
      r = $random(seed);
      chan_a_offset_value = r[12:0];
      chan_b_offset_value = r[28:16];
      p = $random(seed);
      s = $random(seed);
      samp_in = p;
      repeat (5) @(posedge clk);
      #1 samp_in = s;
      repeat (c1[7:6]) @(posedge clk);
      #1 check("early", {converter_chan_a, converter_chan_b}, dp(p));
      @(posedge clk);
      #1 check("out", {converter_chan_a, converter_chan_b}, dp(s));
    end
    for (i = 0; i < 4; i++) begin
      {pll_locked, dll_locked} = i[1:0];
      repeat (6) @(posedge clk);
      #1 h.rd(5'h00, d);
      check("lock", d, {i[1:0], 6'h14});
    end
    h.wr(5'h01, 8'h08);
    for (i = 0; i < 4; i++) begin
      h.wr(5'h03, i == 0 ? 8'h70 : 8'h00);
      ev = i == 0 ? 3'h7 : 3'h4 >> (i - 1);
      fx = i == 0 ? 3'h0 : ev;
      {selftest_failed, fifo_overrun, fifo_word_valid} = ev;
      @(posedge clk);
      #1 {selftest_failed, fifo_overrun, fifo_word_valid} = 3'h0;
      h.rd(5'h04, d);
      check("flags", d, {1'b0, fx, 4'h0});
      check("serial", serial_out_pin, fx[2]);
      h.wr(5'h04, 8'hff);
      h.rd(5'h04, d);
      check("kept", d, {1'b0, fx, 4'h0});
      for (j = 0; j < 8; j++) begin
        fifo_word_valid = 1'b1;
        fifo_word = j[0] ? 16'h5555 : 16'haaaa;
        @(posedge clk);
        #1;
      end
      fifo_word_valid = 1'b0;
      fifo_word = 16'h1234;
      h.wr(5'h04, 8'h00);
      h.rd(5'h04, d);
      check("cleared", d, 8'h00);
    end
    for (i = 0; i < 2; i++) begin
      fifo_sync_disable = i[0];
      h.wr(5'h03, 8'h00);
      n = loads;
      h.wr(5'h03, 8'h02);
      repeat (3) @(posedge clk);
      #1 check("load", loads - n, !i[0]);
      check("tx", tx_enable, 1'b1);
    end
    h.wr(5'h03, 8'h01);
    sync_pin_level = 1'b1;
    repeat (8) @(posedge clk);
    #1 check("pin only", tx_enable, 1'b0);
    h.wr(5'h03, 8'h00);
    repeat (8) @(posedge clk);
    #1 check("pin", tx_enable, 1'b1);
    // overrun and zero write in one cycle: the set wins
    fifo_overrun = 1'b1;
    fork
      h.wr(5'h04, 8'h00);
      begin
        @(posedge clk);
        #1 fifo_overrun = 1'b0;
      end
    join
    h.rd(5'h04, d);
    check("set wins", d, 8'h20);
    // a write while the clock enable is low is not taken
    clk_en = 1'b0;
    h.wr(5'h01, 8'h00);
    clk_en = 1'b1;
    h.rd(5'h01, d);
    check("freeze", d, 8'h08);
    // reset again in mid run
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    h.rd(5'h04, d);
    check("reset flags", d, 8'h00);
    h.rd(5'h01, d);
    check("reset cfg1", d, 8'h10);
    check("reset mode", mode, 8'he0);
    complete_run();
  end
endmodule : tb_dacdp_cfg_regs

// ### core/dacdp_cfg_regs.sv
// datapath control and status registers with routing and sync logic
`timescale 1ns/1ps
`include "dacdp_regs.svh"

module dacdp_cfg_regs #(
  // arbitrary values, not tied to any part
  parameter logic [2:0] PART_IDENT_FIELD = 3'h5,
  parameter logic [1:0] REG_SET_REVISION = 2'h0
) (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 clk_en,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [4:0]           reg_addr,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rd_data,
  input  wire logic                 pll_locked,
  input  wire logic                 dll_locked,
  input  wire logic                 sync_pin_level,
  input  wire logic                 fifo_sync_disable,
  input  wire logic [12:0]          chan_a_offset_value,
  input  wire logic [12:0]          chan_b_offset_value,
  input  wire dacdp_pkg::dacdp_pair_t samp_in,
  input  wire logic                 fifo_word_valid,
  input  wire logic [15:0]          fifo_word,
  input  wire logic                 selftest_failed,
  input  wire logic                 fifo_overrun,
  output dacdp_pkg::dacdp_mode_t    mode,
  output logic                      core_selftest_on,
  output logic      [2:0]           fifo_ptr_offset,
  output logic                      fifo_offset_load,
  output logic                      tx_enable,
  output logic                      serial_out_pin,
  output logic                      serial_out_drive,
  output logic      [15:0]          converter_chan_a,
  output logic      [15:0]          converter_chan_b
);

  dacdp_pkg::dacdp_state_t st;
  dacdp_pkg::dacdp_state_t next_st;

  logic [2:0]             flags;
  logic                   wr_flags;
  logic                   pat_evt;
  logic                   eff_sync;
  logic                   sync_rise;
  logic [7:0]             lock_and_identity_status;
  dacdp_pkg::dacdp_pair_t fmt;
  dacdp_pkg::dacdp_pair_t offs;
  dacdp_pkg::dacdp_pair_t routed;

  assign wr_flags = reg_wr && (reg_addr == `DACDP_ADDR_FLAGS);

  // checkerboard compare on every valid fifo word
  assign pat_evt = fifo_word_valid
                && (fifo_word != `DACDP_PAT_A)
                && (fifo_word != `DACDP_PAT_B);

  dacdp_err_flags u_flags (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .set_evt  ({selftest_failed, fifo_overrun, pat_evt}),
    .mask     (st.cfg3.err_mask),
    .clr_wr   (wr_flags),
    .clr_data (reg_wdata[`DACDP_FLAG_MSB:`DACDP_FLAG_LSB]),
    .flags    (flags)
  );

  // sync source selection
  always_comb begin
    if (st.cfg3.soft_sync_only) begin
      eff_sync = st.cfg3.soft_sync_bit;
    end else begin
      eff_sync = st.cfg3.soft_sync_bit | st.lvl[2];
    end
  end

  assign sync_rise = eff_sync && !st.sync_prev;

  assign lock_and_identity_status = {st.lvl[0], st.lvl[1], 1'b0,
                    PART_IDENT_FIELD, REG_SET_REVISION};

  // input format, offset and routing
  always_comb begin
    fmt = samp_in;
    if (!st.cfg2.twos_comp) begin
      fmt.a[15] = ~samp_in.a[15];
      fmt.b[15] = ~samp_in.b[15];
    end
    offs = fmt;
    if (st.cfg3.offset_on) begin
      offs.a = fmt.a + {{3{chan_a_offset_value[12]}},
                        chan_a_offset_value};
      offs.b = fmt.b + {{3{chan_b_offset_value[12]}},
                        chan_b_offset_value};
    end
    routed = offs;
    if (st.cfg3.swap_channel_outputs) begin
      routed.a = offs.b;
      routed.b = offs.a;
    end
    if (st.cfg3.copy_a_to_b) begin
      routed.b = routed.a;
    end
  end

  always_comb begin
    next_st = st;
    // pin inputs: three flops, level moves when last two agree
    next_st.s0 = {sync_pin_level, dll_locked, pll_locked};
    next_st.s1 = st.s0;
    next_st.s2 = st.s1;
    next_st.lvl = (~(st.s1 ^ st.s2) & st.s2)
                | ((st.s1 ^ st.s2) & st.lvl);
    next_st.sync_prev = eff_sync;
    next_st.tx_en = eff_sync;
    next_st.load = sync_rise && !fifo_sync_disable;
    // output delay line
    next_st.pipe[0] = routed;
    next_st.pipe[1] = st.pipe[0];
    next_st.pipe[2] = st.pipe[1];
    if (st.cfg1.out_delay == 2'h0) begin
      next_st.out = routed;
    end else begin
      next_st.out = st.pipe[st.cfg1.out_delay - 2'h1];
    end
    // register writes
    if (reg_wr) begin
      unique case (reg_addr)
        `DACDP_ADDR_CFG1: begin
          next_st.cfg1 = reg_wdata & `DACDP_WMASK_CFG1;
        end
        `DACDP_ADDR_CFG2: begin
          next_st.cfg2 = reg_wdata & `DACDP_WMASK_CFG2;
        end
        `DACDP_ADDR_CFG3: begin
          next_st.cfg3 = reg_wdata & `DACDP_WMASK_CFG3;
        end
        default: begin
          next_st.cfg1 = st.cfg1;
        end
      endcase
    end
    // register reads, unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        `DACDP_ADDR_LOCK_AND_IDENTITY_STATUS: next_st.rdata = lock_and_identity_status;
        `DACDP_ADDR_CFG1:    next_st.rdata = st.cfg1;
        `DACDP_ADDR_CFG2:    next_st.rdata = st.cfg2;
        `DACDP_ADDR_CFG3:    next_st.rdata = st.cfg3;
        `DACDP_ADDR_FLAGS: begin
          next_st.rdata = 8'h00;
          next_st.rdata[`DACDP_FLAG_MSB:`DACDP_FLAG_LSB] = flags;
        end
        default:             next_st.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st           <= '0;
      st.cfg1      <= `DACDP_RST_CFG1;
      st.cfg2      <= `DACDP_RST_CFG2;
      st.cfg3      <= `DACDP_RST_CFG3;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign reg_rd_data              = st.rdata;
  assign mode.filter_on           = st.cfg1.filter_on;
  assign mode.twos_comp           = st.cfg2.twos_comp;
  assign mode.dual_mode           = st.cfg2.dual_mode;
  assign mode.interp_ratio_select = st.cfg2.interp_ratio_select;
  assign mode.final_mixer_mode    = st.cfg2.final_mixer_mode;
  assign mode.mid_mixer_mode      = st.cfg2.mid_mixer_mode;
  assign core_selftest_on         = st.cfg1.core_selftest_on;
  assign fifo_ptr_offset          = st.cfg1.fifo_offset;
  assign fifo_offset_load         = st.load;
  assign tx_enable                = st.tx_en;
  assign serial_out_drive         = st.cfg1.core_selftest_on;
  assign serial_out_pin           = flags[2];
  assign converter_chan_a         = st.out.a;
  assign converter_chan_b         = st.out.b;

  // checks

  a_pll_status_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `DACDP_ADDR_LOCK_AND_IDENTITY_STATUS
    |=> reg_rd_data[`DACDP_PLL_BIT] == $past(st.lvl[0]))
    else $error("pll lock bit wrong on read");

  a_dll_status_read: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `DACDP_ADDR_LOCK_AND_IDENTITY_STATUS
    |=> reg_rd_data[`DACDP_DLL_BIT] == $past(st.lvl[1]))
    else $error("dll lock bit wrong on read");

  a_ident_fixed: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && reg_rd && reg_addr == `DACDP_ADDR_LOCK_AND_IDENTITY_STATUS
    |=> reg_rd_data[4:0] == {PART_IDENT_FIELD, REG_SET_REVISION})
    else $error("identity fields changed");

  a_delay_two: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg1.out_delay == 2'h2 && $stable(st.cfg1)
    |=> {converter_chan_a, converter_chan_b} == $past(st.pipe[1]))
    else $error("output delay not applied");

  a_offset_load: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && sync_rise && !fifo_sync_disable
    |=> fifo_offset_load)
    else $error("fifo offset not reloaded on sync");

  a_sync_disable: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && fifo_sync_disable |=> !fifo_offset_load)
    else $error("offset reloaded while disabled");

  a_soft_only: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg3.soft_sync_only
    |=> tx_enable == $past(st.cfg3.soft_sync_bit))
    else $error("pins not ignored in soft-only mode");

  a_swap_path: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg3.swap_channel_outputs && !st.cfg3.copy_a_to_b
    |=> st.pipe[0].a == $past(offs.b) && st.pipe[0].b == $past(offs.a))
    else $error("swap not applied");

  a_copy_path: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> st.pipe[0].b == st.pipe[0].a
            || !$past(st.cfg3.copy_a_to_b))
    else $error("copy not applied");

  a_pattern_set: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && pat_evt && !st.cfg3.err_mask[0] |=> flags[0])
    else $error("pattern mismatch not flagged");

  a_mask_blocks: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg3.err_mask[1] && !flags[1] |=> !flags[1])
    else $error("masked fifo flag was set");

  a_sticky_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && flags[2] && !(wr_flags && !reg_wdata[6]) |=> flags[2])
    else $error("sticky flag lost");

  a_serial_out: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && selftest_failed && !st.cfg3.err_mask[2]
    |=> serial_out_pin)
    else $error("serial pin not showing self test flag");

  a_delay_zero: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg1.out_delay == 2'h0
    |=> {converter_chan_a, converter_chan_b} == $past(routed))
    else $error("zero delay output wrong");

  a_delay_one: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg1.out_delay == 2'h1
    |=> {converter_chan_a, converter_chan_b} == $past(st.pipe[0]))
    else $error("one cycle delay output wrong");

  a_delay_three: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg1.out_delay == 2'h3
    |=> {converter_chan_a, converter_chan_b} == $past(st.pipe[2]))
    else $error("three cycle delay output wrong");

  a_format_flip: assert property (
    @(posedge clk) disable iff (sys_rst)
    !st.cfg2.twos_comp
    |-> fmt.a[15] != samp_in.a[15] && fmt.b[15] != samp_in.b[15])
    else $error("offset binary not converted");

  a_offset_sum: assert property (
    @(posedge clk) disable iff (sys_rst)
    st.cfg3.offset_on
    |-> offs.a == fmt.a + {{3{chan_a_offset_value[12]}},
                           chan_a_offset_value})
    else $error("channel offset not added");

  a_tx_follow: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en |=> tx_enable == $past(eff_sync))
    else $error("transmit enable not following sync");

  a_selftest_set: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && selftest_failed && !st.cfg3.err_mask[2] |=> flags[2])
    else $error("self test failure not flagged");

  a_fifo_set: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && fifo_overrun && !st.cfg3.err_mask[1] |=> flags[1])
    else $error("fifo overrun not flagged");

  a_flag_clear: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && wr_flags && !reg_wdata[5]
    && !(fifo_overrun && !st.cfg3.err_mask[1]) |=> !flags[1])
    else $error("fifo flag not cleared by zero write");

  a_mask_self: assert property (
    @(posedge clk) disable iff (sys_rst)
    clk_en && st.cfg3.err_mask[2] && !flags[2] |=> !flags[2])
    else $error("masked self test flag was set");

  a_cfg1_hold: assert property (
    @(posedge clk) disable iff (sys_rst)
    !(clk_en && reg_wr && reg_addr == `DACDP_ADDR_CFG1)
    |=> $stable(st.cfg1))
    else $error("config one changed without a write");

endmodule : dacdp_cfg_regs

// ### core/dacdp_err_flags.sv
// sticky error flags with mask gating and write-zero clear
`timescale 1ns/1ps
`include "dacdp_regs.svh"

module dacdp_err_flags (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       clk_en,
  input  wire logic [2:0] set_evt,
  input  wire logic [2:0] mask,
  input  wire logic       clr_wr,
  input  wire logic [2:0] clr_data,
  output logic      [2:0] flags
);

  dacdp_pkg::dacdp_flags_t st;
  dacdp_pkg::dacdp_flags_t next_st;

  wire [2:0] next_bit;

  // per flag: an unmasked event wins over a same-cycle zero write
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_flag
      assign next_bit[i] = (set_evt[i] && !mask[i])
                        || (st.flags[i]
                            && !(clr_wr && !clr_data[i]));
    end
  endgenerate

  always_comb begin
    next_st       = st;
    next_st.flags = next_bit;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st.flags <= `DACDP_RST_FLAGS;
    end else if (clk_en) begin
      st <= next_st;
    end
  end

  assign flags = st.flags;

endmodule : dacdp_err_flags

// ### core/dacdp_pkg.sv
// types shared by the datapath configuration block
package dacdp_pkg;

  typedef enum logic [1:0] {
    DACDP_MIX_LOW  = 2'b00,
    DACDP_MIX_HIGH = 2'b01,
    DACDP_MIX_POS  = 2'b10,
    DACDP_MIX_NEG  = 2'b11
  } dacdp_mix_t;

  typedef struct packed {
    logic [1:0] out_delay;
    logic       rsvd;
    logic       filter_on;
    logic       core_selftest_on;
    logic [2:0] fifo_offset;
  } dacdp_cfg1_t;

  typedef struct packed {
    logic       twos_comp;
    logic       dual_mode;
    logic       interp_ratio_select;
    logic       rsvd;
    dacdp_mix_t final_mixer_mode;
    dacdp_mix_t mid_mixer_mode;
  } dacdp_cfg2_t;

  typedef struct packed {
    logic       offset_on;
    logic [2:0] err_mask;
    logic       swap_channel_outputs;
    logic       copy_a_to_b;
    logic       soft_sync_bit;
    logic       soft_sync_only;
  } dacdp_cfg3_t;

  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
  } dacdp_pair_t;

  typedef struct packed {
    logic       filter_on;
    logic       twos_comp;
    logic       dual_mode;
    logic       interp_ratio_select;
    dacdp_mix_t final_mixer_mode;
    dacdp_mix_t mid_mixer_mode;
  } dacdp_mode_t;

  typedef struct packed {
    logic [2:0] flags;
  } dacdp_flags_t;

  typedef struct packed {
    dacdp_cfg1_t      cfg1;
    dacdp_cfg2_t      cfg2;
    dacdp_cfg3_t      cfg3;
    logic [2:0]       s0;
    logic [2:0]       s1;
    logic [2:0]       s2;
    logic [2:0]       lvl;
    logic             sync_prev;
    logic             load;
    logic             tx_en;
    dacdp_pair_t [2:0] pipe;
    dacdp_pair_t      out;
    logic [7:0]       rdata;
  } dacdp_state_t;

endpackage : dacdp_pkg

// ### core/dacdp_regs.svh
// register offsets, field positions, reset values and constants
`ifndef DACDP_REGS_SVH
`define DACDP_REGS_SVH

`define DACDP_ADDR_LOCK_AND_IDENTITY_STATUS 5'h00
`define DACDP_ADDR_CFG1    5'h01
`define DACDP_ADDR_CFG2    5'h02
`define DACDP_ADDR_CFG3    5'h03
`define DACDP_ADDR_FLAGS   5'h04

`define DACDP_RST_CFG1     8'h10
`define DACDP_RST_CFG2     8'hc0
`define DACDP_RST_CFG3     8'h70
`define DACDP_RST_FLAGS    3'h0

`define DACDP_WMASK_CFG1   8'hdf
`define DACDP_WMASK_CFG2   8'hef
`define DACDP_WMASK_CFG3   8'hff

`define DACDP_FLAG_LSB     4
`define DACDP_FLAG_MSB     6
`define DACDP_PLL_BIT      7
`define DACDP_DLL_BIT      6

`define DACDP_PAT_A        16'haaaa
`define DACDP_PAT_B        16'h5555
`define DACDP_DLY_STAGES   3
`define DACDP_SYNC_FLOPS   3

`endif
